/* File: common/mm_link_if.sv */
// link carrying master and slave port signals between the two ends
`timescale 1ns/1ps
interface mm_link_if #(
   parameter int DW = mm_pkg::DATA_W,
   parameter int AW = mm_pkg::ADDR_W
);
   logic m_read; // master read request
   logic m_write; // master write request
   logic m_discard; // master drops pending reads
   logic [AW-1:0] m_addr; // master address
   logic [DW/8-1:0] m_be; // master byte lanes
   logic [DW-1:0] m_wdata; // master write word
   logic m_stall; // fabric stall request
   logic m_rd_valid; // read return valid
   logic [DW-1:0] m_rdata; // returned read word
   logic m_pkt_last; // packet-last toward master
   logic s_sel; // slave select
   logic s_read; // slave read
   logic s_write; // slave write
   logic [AW-1:0] s_addr; // slave address
   logic [DW/8-1:0] s_be; // slave byte lanes
   logic [DW-1:0] s_wdata; // slave write word
   logic [DW-1:0] s_rdata; // slave read word
   logic s_space_ok; // write-space-ok
   logic s_fill_ok; // read-fill-ok
   logic s_pkt_last; // packet-last from slave
   // port logic: pipelined master and flow-controlled slave
   modport port_side (
      output m_read, m_write, m_discard, m_addr, m_be, m_wdata,
      input m_stall, m_rd_valid, m_rdata, m_pkt_last,
      input s_sel, s_read, s_write, s_addr, s_be, s_wdata,
      output s_rdata, s_space_ok, s_fill_ok, s_pkt_last
   );
   // interconnect fabric
   modport fabric_side (
      input m_read, m_write, m_discard, m_addr, m_be, m_wdata,
      output m_stall, m_rd_valid, m_rdata, m_pkt_last,
      output s_sel, s_read, s_write, s_addr, s_be, s_wdata,
      input s_rdata, s_space_ok, s_fill_ok, s_pkt_last
   );
endinterface

/* File: common/mm_pkg.sv */
// shared constants and types for the pipelined read and flow control ports
//
// Summary of operation
// - read-valid input makes the master pipelined
// - master holds read, address, lanes while stalled
// - address phase ends at edge with stall low
// - fabric returns read words in issue order
// - master captures read word only when valid
// - outstanding reads bounded by a design maximum
// - after discard, valid stays low until new read
// - read issued with discard returns next
// - flow control only when both ends use it
// - tristate ports may not use flow control
// - readiness signals leave other timing unchanged
// - write-space-ok low when write would overflow
// - read-fill-ok low when read would underflow
// - fabric forwards only while matching readiness high
// - slave accepts every transfer regardless of readiness
// - packet-last passed on, pulse or held
// - slave works even if packet-last unseen
// - fill-ok high lets next read start
// - fill-ok falls only at end of read
// - read packet-last with its read word
// - each selected read cycle gives new word
// - space-ok falls only at end of write
// - write packet-last at write capture edge
package mm_pkg;
   // ************************************************************
   // widths and counts
   // ************************************************************
   localparam int DATA_W = 32; // bus word width
   localparam int ADDR_W = 16; // address width
   localparam int MAX_PEND = 4; // outstanding read ceiling
   localparam int FIFO_DEPTH = 4; // slave storage depth
   localparam int PKT_LEN = 4; // write words per packet
   localparam int RET_LAT = 2; // fabric return stages
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic BIT_RST = 1'b0; // single control bits
   localparam logic [7:0] CNT_RST = 8'h00; // counters
   // ************************************************************
   // master address phase states
   // ************************************************************
   typedef enum logic [1:0] {
      M_IDLE = 2'b01, // no request on the bus
      M_ADDR = 2'b10 // address phase in progress
   } mst_state_t;
endpackage

/* File: dv/mm_link_props.sv */
// assertions on the link between the port end and the fabric end
`timescale 1ns/1ps
module mm_link_props #(
   parameter int MAX_PEND = 4,
   parameter int RET_LAT = 2
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic m_read,
   input wire logic m_write,
   input wire logic m_discard,
   input wire logic [mm_pkg::ADDR_W-1:0] m_addr,
   input wire logic [mm_pkg::DATA_W-1:0] m_wdata,
   input wire logic m_stall,
   input wire logic m_rd_valid,
   input wire logic s_sel,
   input wire logic s_read,
   input wire logic s_write,
   input wire logic s_fill_ok,
   input wire logic s_space_ok
);
   // ************************************************************
   // outstanding read tally
   // ************************************************************
   logic [7:0] owed_r; // reads accepted, not yet returned or dropped
   logic [7:0] owed_nxt; // next tally
   // discard keeps only a read accepted on the same edge
   always_comb begin
      owed_nxt = owed_r + 8'(m_read && !m_stall) - 8'(m_rd_valid);
      if (m_discard)
         owed_nxt = 8'(m_read && !m_stall);
   end
   // register the tally
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         owed_r <= 8'h00;
      else
         owed_r <= owed_nxt;
   end
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // read address phase ending at this edge
   sequence rd_end_s;
      m_read && !m_stall;
   endsequence
   // return strobe quiet for the two return stages
   sequence quiet_s;
      !m_rd_valid [*2];
   endsequence
   hold_req_a: assert property ((m_read || m_write) && m_stall |=>
      $stable({m_read, m_write, m_addr, m_wdata}))
      else $error("request moved while stalled");
   rd_fwd_a: assert property (rd_end_s |-> s_sel && s_read)
      else $error("ended read phase not forwarded");
   stall_why_a: assert property (m_stall |->
      m_read && !s_fill_ok || m_write && !s_space_ok)
      else $error("stall without a readiness cause");
   stall_nofwd_a: assert property (m_stall |-> !s_sel)
      else $error("stalled transfer reached the slave");
   fill_fall_a: assert property ($fell(s_fill_ok) |->
      $past(s_sel && s_read))
      else $error("fill ok fell outside a read");
   space_fall_a: assert property ($fell(s_space_ok) |->
      $past(s_sel && s_write))
      else $error("space ok fell outside a write");
   dsc_quiet_a: assert property (m_discard && !(m_read && !m_stall)
      |=> quiet_s)
      else $error("return after discard");
   dsc_new_a: assert property (m_discard ##0 rd_end_s
      |-> ##RET_LAT m_rd_valid)
      else $error("read issued with discard not returned");
   pend_max_a: assert property (owed_r <= 8'(MAX_PEND))
      else $error("too many reads outstanding");
endmodule

/* File: dv/mm_pipelined_read_flow_ctrl_test.sv */
// self-checking bench: port end looped through the fabric end
`timescale 1ns/1ps
module mm_pipelined_read_flow_ctrl_test;
   logic clk_sys, rst_b, cmd_valid, cmd_write, cmd_ready, discard_req;
   logic resp_valid, resp_last, tx_valid, tx_last, tx_ready, rx_valid;
   logic rx_last, rx_ready, master_fc, fc_hold, underflow, overflow, slave_fc;
   logic [mm_pkg::DATA_W-1:0] cmd_wdata, resp_data, tx_data, rx_data;
   logic [7:0] pend_count; // outstanding reads seen by the port
   logic [31:0] rsp_q[$]; // returned read words
   logic lst_q[$]; // returned read marks
   int fails, n_compared, cyc_n, uf_n, of_n;
   mm_link_if link ();
   mm_port_end u_mm_port_end (.clk_sys(clk_sys), .rst_b(rst_b),
      .bus(link), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_addr(cmd_wdata[15:0]), .cmd_be(4'hF), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .discard_req(discard_req),
      .resp_valid(resp_valid), .resp_data(resp_data),
      .resp_last(resp_last), .pend_count(pend_count),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .rx_ready(rx_ready), .pkt_clear(1'h0),
      .overflow(overflow), .underflow(underflow));
   mm_fabric_end #(.RET_LAT(2)) u_mm_fabric_end (.clk_sys(clk_sys),
      .rst_b(rst_b), .bus(link), .master_fc(master_fc),
      .slave_fc(slave_fc), .fc_hold(fc_hold));
   mm_link_props #(.MAX_PEND(4), .RET_LAT(2)) u_props (.clk_sys(clk_sys),
      .rst_b(rst_b), .m_read(link.m_read), .m_write(link.m_write),
      .m_discard(link.m_discard), .m_addr(link.m_addr),
      .m_wdata(link.m_wdata), .m_stall(link.m_stall),
      .m_rd_valid(link.m_rd_valid), .s_sel(link.s_sel),
      .s_read(link.s_read), .s_write(link.s_write),
      .s_fill_ok(link.s_fill_ok), .s_space_ok(link.s_space_ok));
   // clock of 50 ns
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   // hang guard
   always @(posedge clk_sys) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         fails++;
         stop_test();
      end
   end
   // capture one-cycle outputs where settled
   always @(negedge clk_sys) begin
      if (resp_valid === 1'h1) begin
         rsp_q.push_back(resp_data);
         lst_q.push_back(resp_last);
      end
      uf_n += int'(underflow === 1'h1);
      of_n += int'(overflow === 1'h1);
   end
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (fails == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // back-to-back commands, one taken at each edge finding ready high
   task automatic send(logic wr, int n, logic [31:0] base);
      int k;
      k = 0;
      cmd_valid = 1'h1;
      cmd_write = wr;
      cmd_wdata = base;
      while (k < n) begin
         #1;
         if (cmd_ready === 1'h1)
            k++;
         cyc(1);
         cmd_wdata = base + k;
      end
      cmd_valid = 1'h0;
      cyc(1);
   endtask
   task automatic push_tx(logic [31:0] d, logic l);
      tx_valid = 1'h1;
      tx_data = d;
      tx_last = l;
      cyc(1);
      tx_valid = 1'h0;
      cyc(1);
   endtask
   task automatic pop(logic [31:0] d, logic l);
      for (int g = 0; g < 20 && rx_valid !== 1'h1; g++)
         cyc(1);
      check(rx_data, d);
      check(rx_last, l);
      rx_ready = 1'h1;
      cyc(1);
      rx_ready = 1'h0;
      cyc(1);
   endtask
   // fill receive store under flow control until a write stalls
   task automatic t_write_fill();
      master_fc = 1'h1;
      send(1'h1, 5, 32'h0000_1000);
      cyc(2);
      check(link.s_space_ok, 1'h0);
      check(fc_hold, 1'h1);
      check(link.s_sel, 1'h0);
      check(cmd_ready, 1'h0);
      for (int i = 0; i < 5; i++)
         pop(32'h0000_1000 + i, i == 3);
   endtask
   // stalled read released by fill ok, then pipelined reads
   task automatic t_read_flow();
      check(link.s_fill_ok, 1'h0);
      send(1'h0, 1, 32'h0000_0020);
      cyc(3);
      check(link.m_stall, 1'h1);
      for (int i = 0; i < 3; i++)
         push_tx(32'h0000_00A0 + i, i == 2);
      send(1'h0, 2, 32'h0000_0030);
      cyc(6);
      check(rsp_q.size(), 32'h0000_0003);
      for (int i = 0; i < 3; i++) begin
         check(rsp_q.pop_front(), 32'h0000_00A0 + i);
         check(lst_q.pop_front(), i == 2);
      end
      check(link.s_fill_ok, 1'h0);
   endtask
   // without master flow control nothing is held back
   task automatic t_no_fc();
      master_fc = 1'h0;
      uf_n = 0;
      of_n = 0;
      send(1'h0, 1, 32'h0000_0040);
      // master side on, slave side off: still no holding back
      master_fc = 1'h1;
      slave_fc = 1'h0;
      send(1'h1, 5, 32'h0000_2000);
      cyc(5);
      check(rsp_q.size(), 32'h0000_0001);
      rsp_q.delete();
      lst_q.delete();
      check(uf_n, 32'h0000_0001);
      check(of_n, 32'h0000_0001);
      for (int i = 0; i < 4; i++)
         pop(32'h0000_2000 + i, i == 2);
   endtask
   // discard with and without a read issued in the same cycle
   task automatic t_discard();
      master_fc = 1'h1;
      slave_fc = 1'h1;
      for (int i = 0; i < 4; i++)
         push_tx(32'h0000_00B0 + i, 1'h0);
      check(tx_ready, 1'h0);
      cmd_valid = 1'h1;
      cmd_write = 1'h0;
      cyc(2);
      cmd_valid = 1'h0;
      discard_req = 1'h1;
      cyc(1);
      discard_req = 1'h0;
      check(pend_count, 32'h0000_0001);
      cmd_valid = 1'h1;
      cyc(1);
      cmd_valid = 1'h0;
      cyc(1);
      discard_req = 1'h1;
      cyc(1);
      discard_req = 1'h0;
      cyc(5);
      check(pend_count, 32'h0000_0000);
      check(rsp_q.size(), 32'h0000_0001);
      check(rsp_q[0], 32'h0000_00B1);
   endtask
   initial begin
      rst_b = 1'h0;
      cmd_valid = 1'h0;
      cmd_write = 1'h0;
      cmd_wdata = 32'h0000_0000;
      discard_req = 1'h0;
      tx_valid = 1'h0;
      tx_data = 32'h0000_0000;
      tx_last = 1'h0;
      rx_ready = 1'h0;
      master_fc = 1'h1;
      slave_fc = 1'h1;
      cyc(2);
      rst_b = 1'h1;
      check(link.s_space_ok, 1'h1);
      t_write_fill();
      t_read_flow();
      t_no_fc();
      t_discard();
      stop_test();
   end
endmodule

/* File: src/mm_fabric_end.sv */
// interconnect end: forwards master transfers to the slave in order
`timescale 1ns/1ps
module mm_fabric_end #(
   parameter int DW = mm_pkg::DATA_W,
   parameter int AW = mm_pkg::ADDR_W,
   parameter int RET_LAT = mm_pkg::RET_LAT
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   mm_link_if.fabric_side bus,
   input wire logic master_fc,
   input wire logic slave_fc,
   output logic fc_hold
);
   // ************************************************************
   // parameter check
   // ************************************************************
   if (RET_LAT < 1 || RET_LAT > 16) begin : g_lat
      $error("RET_LAT must be 1 to 16");
   end
   logic fc_on; // pair uses flow control
   logic ok_rd, ok_wr; // transfer may pass to slave
   logic pass_rd, pass_wr; // transfer passed this cycle
   logic v_r [RET_LAT]; // return stage valid
   logic v_nxt [RET_LAT];
   logic [DW:0] d_r [RET_LAT]; // return stage {last, word}
   logic [DW:0] d_nxt [RET_LAT];

   // ************************************************************
   // request forwarding
   // ************************************************************
   // readiness counts only if both ends use it
   assign fc_on = master_fc && slave_fc;
   // forward only while the matching readiness is high
   assign ok_rd = !fc_on || bus.s_fill_ok;
   assign ok_wr = !fc_on || bus.s_space_ok;
   assign pass_rd = bus.m_read && ok_rd;
   assign pass_wr = bus.m_write && ok_wr;
   assign bus.s_sel = pass_rd || pass_wr;
   assign bus.s_read = pass_rd;
   assign bus.s_write = pass_wr;
   assign bus.s_addr = bus.m_addr;
   assign bus.s_be = bus.m_be;
   assign bus.s_wdata = bus.m_wdata;
   // held master is stalled
   assign bus.m_stall = (bus.m_read && !ok_rd)
                      || (bus.m_write && !ok_wr);
   assign fc_hold = bus.m_stall;

   // ************************************************************
   // in-order return pipe
   // ************************************************************
   for (genvar k = 0; k < RET_LAT; k++) begin : g_ret
      if (k == 0) begin : g_first
         // word of a read passed now is kept even on discard
         assign v_nxt[k] = pass_rd;
         assign d_nxt[k] = {bus.s_pkt_last, bus.s_rdata};
      end else begin : g_next
         // older words move in order or are dropped
         assign v_nxt[k] = v_r[k-1] && !bus.m_discard;
         assign d_nxt[k] = d_r[k-1];
      end
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            v_r[k] <= mm_pkg::BIT_RST;
            d_r[k] <= '0;
         end else begin
            v_r[k] <= v_nxt[k];
            d_r[k] <= d_nxt[k];
         end
      end
   end

   assign bus.m_rd_valid = v_r[RET_LAT-1];
   assign bus.m_rdata = d_r[RET_LAT-1][DW-1:0];
   // read mark with its word, write mark passed straight on unless a read word returns that cycle
   assign bus.m_pkt_last = v_r[RET_LAT-1] ? d_r[RET_LAT-1][DW]
                                          : (pass_wr && bus.s_pkt_last);
endmodule

/* File: src/mm_port_end.sv */
// port logic: pipelined read master and flow-controlled stream slave
`timescale 1ns/1ps
module mm_port_end #(
   parameter int DW = mm_pkg::DATA_W,
   parameter int AW = mm_pkg::ADDR_W,
   parameter int MAX_PEND = mm_pkg::MAX_PEND,
   parameter int DEPTH = mm_pkg::FIFO_DEPTH,
   parameter int PKT_LEN = mm_pkg::PKT_LEN,
   parameter bit PKT_HOLD = 1'b0,
   parameter bit TRISTATE = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   mm_link_if.port_side bus,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [AW-1:0] cmd_addr,
   input wire logic [DW/8-1:0] cmd_be,
   input wire logic [DW-1:0] cmd_wdata,
   output logic cmd_ready,
   input wire logic discard_req,
   output logic resp_valid,
   output logic [DW-1:0] resp_data,
   output logic resp_last,
   output logic [7:0] pend_count,
   input wire logic tx_valid,
   input wire logic [DW-1:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready,
   output logic rx_valid,
   output logic [DW-1:0] rx_data,
   output logic rx_last,
   input wire logic rx_ready,
   input wire logic pkt_clear,
   output logic overflow,
   output logic underflow
);
   // ************************************************************
   // parameter checks
   // ************************************************************
   if (TRISTATE) begin : g_tri
      $error("flow control signals are not allowed on tristate ports");
   end
   if (MAX_PEND < 1 || MAX_PEND > 255) begin : g_pend
      $error("MAX_PEND must be 1 to 255");
   end
   if (PKT_LEN < 1 || PKT_LEN > 256) begin : g_pkt
      $error("PKT_LEN must be 1 to 256");
   end
   if (DW % 8 != 0) begin : g_dw
      $error("DW must be a whole number of bytes");
   end

   // ************************************************************
   // pipelined master: address phase
   // ************************************************************
   mm_pkg::mst_state_t state_r, state_nxt; // address phase state
   logic rd_r, rd_nxt; // read strobe driven
   logic wr_r, wr_nxt; // write strobe driven
   logic [AW-1:0] addr_r, addr_nxt; // address driven
   logic [DW/8-1:0] be_r, be_nxt; // lanes driven
   logic [DW-1:0] wd_r, wd_nxt; // write word driven
   logic phase_end; // address phase ends this edge
   logic took_rd; // a read address accepted this edge
   logic slot_free; // master may release the bus now
   logic room; // another read fits under the ceiling
   logic load; // new request enters address phase
   logic [7:0] pend_r, pend_nxt; // outstanding reads

   // phase ends on the first edge with stall low
   assign phase_end = (state_r == mm_pkg::M_ADDR) && !bus.m_stall;
   assign took_rd = phase_end && rd_r;
   assign slot_free = (state_r == mm_pkg::M_IDLE) || phase_end;
   // count the read in flight as already pending
   assign room = ({1'b0, pend_r} + {8'h00, took_rd}) < 9'(MAX_PEND);
   // back to back request in the cycle the phase ends
   assign cmd_ready = slot_free && (cmd_write || room);
   assign load = cmd_valid && cmd_ready;

   // next values of the address phase
   always_comb begin
      state_nxt = state_r;
      rd_nxt = rd_r;
      wr_nxt = wr_r;
      addr_nxt = addr_r;
      be_nxt = be_r;
      wd_nxt = wd_r;
      if (load) begin
         // new request presented
         state_nxt = mm_pkg::M_ADDR;
         rd_nxt = !cmd_write;
         wr_nxt = cmd_write;
         addr_nxt = cmd_addr;
         be_nxt = cmd_be;
         wd_nxt = cmd_wdata;
      end else if (phase_end) begin
         // request taken, bus goes quiet
         state_nxt = mm_pkg::M_IDLE;
         rd_nxt = mm_pkg::BIT_RST;
         wr_nxt = mm_pkg::BIT_RST;
      end
      // otherwise everything holds while stalled
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= mm_pkg::M_IDLE;
         rd_r <= mm_pkg::BIT_RST;
         wr_r <= mm_pkg::BIT_RST;
         addr_r <= '0;
         be_r <= '0;
         wd_r <= '0;
      end else begin
         state_r <= state_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         addr_r <= addr_nxt;
         be_r <= be_nxt;
         wd_r <= wd_nxt;
      end
   end

   assign bus.m_read = rd_r;
   assign bus.m_write = wr_r;
   assign bus.m_addr = addr_r;
   assign bus.m_be = be_r;
   assign bus.m_wdata = wd_r;
   // discard may share a cycle with a new read
   assign bus.m_discard = discard_req;

   // ************************************************************
   // pipelined master: outstanding count and returns
   // ************************************************************
   logic rv_r, rv_nxt; // returned word valid
   logic [DW-1:0] rdat_r, rdat_nxt; // returned word
   logic rlast_r, rlast_nxt; // returned packet-last

   // outstanding count next value
   always_comb begin
      pend_nxt = pend_r;
      if (discard_req) begin
         // only a read taken now survives a discard
         pend_nxt = {7'h00, took_rd};
      end else if (took_rd && !(bus.m_rd_valid && pend_r != '0)) begin
         pend_nxt = pend_r + 8'h01;
      end else if (!took_rd && bus.m_rd_valid && pend_r != '0) begin
         pend_nxt = pend_r - 8'h01;
      end
   end

   // returned word next values, returns lag issue freely
   always_comb begin
      // read word lines looked at only when valid
      rv_nxt = bus.m_rd_valid;
      rdat_nxt = bus.m_rd_valid ? bus.m_rdata : rdat_r;
      rlast_nxt = bus.m_rd_valid && bus.m_pkt_last;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pend_r <= mm_pkg::CNT_RST;
         rv_r <= mm_pkg::BIT_RST;
         rdat_r <= '0;
         rlast_r <= mm_pkg::BIT_RST;
      end else begin
         pend_r <= pend_nxt;
         rv_r <= rv_nxt;
         rdat_r <= rdat_nxt;
         rlast_r <= rlast_nxt;
      end
   end

   assign resp_valid = rv_r;
   assign resp_data = rdat_r;
   assign resp_last = rlast_r;
   assign pend_count = pend_r;

   // ************************************************************
   // flow-controlled slave: storage
   // ************************************************************
   logic [DW:0] tx_head; // {last, word} for bus reads
   logic tx_full, tx_empty; // transmit store state
   logic [DW:0] rx_head; // {last, word} to user
   logic rx_full, rx_empty; // receive store state
   logic [DW-1:0] wmask; // write word with lanes applied
   logic bus_rd, bus_wr; // selected slave transfers
   logic wlast; // this write closes a packet
   logic [7:0] wcnt_r, wcnt_nxt; // words of current packet

   // selected transfers are always taken
   assign bus_rd = bus.s_sel && bus.s_read;
   assign bus_wr = bus.s_sel && bus.s_write;
   assign wlast = (wcnt_r == 8'(PKT_LEN - 1));

   // byte lanes: unselected lanes store as zero
   for (genvar b = 0; b < DW / 8; b++) begin : g_lane
      assign wmask[8*b +: 8] = bus.s_be[b] ? bus.s_wdata[8*b +: 8]
                                           : 8'h00;
   end

   // words the slave hands out on reads
   word_fifo #(.W(DW + 1), .DEPTH(DEPTH)) u_tx (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .push(tx_valid),
      .push_data({tx_last, tx_data}),
      .pop(bus_rd),
      .head(tx_head),
      .full(tx_full),
      .empty(tx_empty)
   );

   // words the slave captures on writes
   word_fifo #(.W(DW + 1), .DEPTH(DEPTH)) u_rx (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .push(bus_wr),
      .push_data({wlast, wmask}),
      .pop(rx_ready),
      .head(rx_head),
      .full(rx_full),
      .empty(rx_empty)
   );

   assign tx_ready = !tx_full;
   assign rx_valid = !rx_empty;
   assign rx_data = rx_head[DW-1:0];
   assign rx_last = rx_head[DW];
   assign bus.s_rdata = tx_head[DW-1:0];
   // from registered fill, so it moves only at an edge
   assign bus.s_space_ok = !rx_full;
   // same for the read side
   assign bus.s_fill_ok = !tx_empty;

   // ************************************************************
   // flow-controlled slave: packet marking and errors
   // ************************************************************
   logic mark_now; // packet-last for this transfer
   logic hold_r, hold_nxt; // held packet-last
   logic ovf_r, ovf_nxt; // write into full store
   logic unf_r, unf_nxt; // read from empty store

   // read mark rides with the word it belongs to
   // write mark stands during the capturing cycle
   assign mark_now = (bus_rd && tx_head[DW] && !tx_empty)
                   || (bus_wr && wlast);

   // packet counter, hold flag and error pulses
   always_comb begin
      wcnt_nxt = wcnt_r;
      if (bus_wr) begin
         wcnt_nxt = wlast ? mm_pkg::CNT_RST : wcnt_r + 8'h01;
      end
      // a set wins over a clear, nothing waits on it
      hold_nxt = PKT_HOLD && (mark_now || (hold_r && !pkt_clear));
      // dropped or stale words flagged, except a write dropped while rx_ready pops the full store, bus never stalls
      ovf_nxt = bus_wr && rx_full && !rx_ready;
      unf_nxt = bus_rd && tx_empty;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wcnt_r <= mm_pkg::CNT_RST;
         hold_r <= mm_pkg::BIT_RST;
         ovf_r <= mm_pkg::BIT_RST;
         unf_r <= mm_pkg::BIT_RST;
      end else begin
         wcnt_r <= wcnt_nxt;
         hold_r <= hold_nxt;
         ovf_r <= ovf_nxt;
         unf_r <= unf_nxt;
      end
   end

   // pulse form, or pulse then held
   assign bus.s_pkt_last = mark_now || hold_r;
   assign overflow = ovf_r;
   assign underflow = unf_r;
endmodule

/* File: src/word_fifo.sv */
// flip-flop word store used as slave storage
`timescale 1ns/1ps
module word_fifo #(
   parameter int W = 8,
   parameter int DEPTH = mm_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic push,
   input wire logic [W-1:0] push_data,
   input wire logic pop,
   output logic [W-1:0] head,
   output logic full,
   output logic empty
);
   localparam int PW = $clog2(DEPTH); // pointer width
   localparam int CW = PW + 1; // fill count width
   // ************************************************************
   // parameter check
   // ************************************************************
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("word_fifo depth must be a power of two, 2 or more");
   end
   logic [W-1:0] mem_r [DEPTH]; // storage entries
   logic [W-1:0] mem_nxt [DEPTH];
   logic [PW-1:0] wp_r, wp_nxt; // write pointer
   logic [PW-1:0] rp_r, rp_nxt; // read pointer
   logic [CW-1:0] cnt_r, cnt_nxt; // words held
   logic do_push, do_pop; // effective moves
   assign full = (cnt_r == CW'(DEPTH));
   assign empty = (cnt_r == '0);
   assign head = mem_r[rp_r];
   assign do_push = push && !full;
   assign do_pop = pop && !empty;
   // pointer and count next values
   always_comb begin
      wp_nxt = do_push ? wp_r + 1'b1 : wp_r;
      rp_nxt = do_pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r;
      if (do_push && !do_pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (do_pop && !do_push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   // one register per entry, loaded when the write pointer hits it
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      assign mem_nxt[i] = (do_push && wp_r == PW'(i)) ? push_data
                                                        : mem_r[i];
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            mem_r[i] <= '0;
         end else begin
            mem_r[i] <= mem_nxt[i];
         end
      end
   end
endmodule
